// file: rtl/gpio_input_debounce.v
// Two-stage debounce filter and change detection for general-purpose inputs
//
// Functional notes
// - Each input passes two register stages
// - Both stages share one 50 us tick
// - New level enters stage one on tick
// - Stage two updates only when level stable
// - Filter delay ranges up to two periods
// - Reset low at least 120 us
// - Any level_o edge on an input-mode pin raises event
// - Output-mode pins never raise events
`timescale 1ns/1ns
`include "gpio_input_debounce_consts.vh"
module gpio_input_debounce #(
    parameter N_PINS     = 18,
    parameter PERIOD_CYC = `FILTER_PERIOD_CYC
) (
    input  wire              clk_sys_i,
    input  wire              rst_n_i,
    input  wire [N_PINS-1:0] pin_i,
    input  wire [N_PINS-1:0] dir_out_i,
    input  wire              filter_en_i,
    output wire [N_PINS-1:0] level_o,
    output wire [N_PINS-1:0] change_o,
    output wire              tick_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Divider width follows the period, so a long period cannot wrap early
    function integer width_for;
        input integer value;
        integer       w;

        begin
            w = 1;
            while ((1 << w) < value) begin
                w = w + 1;
            end
            width_for = w;
        end
    endfunction

    // Level handed to change detection: filtered stage or raw pin
    function pick_level;
        input filt_en;
        input filt_bit;
        input raw_bit;
        begin
            pick_level = filt_en ? filt_bit : raw_bit;
        end
    endfunction

    // Level change, masked for pins driven as outputs
    function edge_event;
        input new_bit;
        input old_bit;
        input is_output;
        begin
            edge_event = (new_bit ^ old_bit) & ~is_output;
        end
    endfunction

    // Second stage may only follow the first while the pin agrees
    function stage_agree;
        input pin_bit;
        input held_bit;
        begin
            stage_agree = (pin_bit == held_bit);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Shared filter tick and per-pin vectors

    localparam CW = width_for(PERIOD_CYC);

    wire              tick;
    wire [N_PINS-1:0] stage1_vec;
    wire [N_PINS-1:0] stage2_vec;
    wire [N_PINS-1:0] level_vec;
    wire [N_PINS-1:0] level_next_vec;
    wire [N_PINS-1:0] change_vec;

    // One divider for all pins, so every stage sees the same edge
    // Tick runs free from reset; it is not aligned to any pin edge
    filter_tick_gen #(
        .PERIOD_CYC (PERIOD_CYC),
        .CW         (CW)
    ) u_tick (
        .clk_sys_i  (clk_sys_i),
        .rst_n_i    (rst_n_i),
        .tick_o     (tick)
    );

    assign tick_o   = tick;
    assign level_o  = level_vec;
    assign change_o = change_vec;

    genvar g;

    ////////////////////////////////////////////////////////////////////////////
    // First stage: new level captured on one tick

    generate
        for (g = 0; g < N_PINS; g = g + 1) begin : g_stage1
            reg stage1_reg;
            reg stage1_next;

            always @* begin
                stage1_next = stage1_reg;
                // Pin may move anywhere in a period: up to one period late
                if (tick) begin
                    stage1_next = pin_i[g];
                end
            end

            always @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    stage1_reg <= `PINS_RESET;
                end else begin
                    stage1_reg <= stage1_next;
                end
            end

            assign stage1_vec[g] = stage1_reg;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Second stage: follows only a level held across two ticks

    generate
        for (g = 0; g < N_PINS; g = g + 1) begin : g_stage2
            reg stage2_reg;
            reg stage2_next;

            always @* begin
                stage2_next = stage2_reg;
                // A pulse shorter than one tick spacing never gets here
                if (tick && stage_agree(pin_i[g], stage1_vec[g])) begin
                    stage2_next = stage1_vec[g];
                end
            end

            always @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    stage2_reg <= `PINS_RESET;
                end else begin
                    stage2_reg <= stage2_next;
                end
            end

            assign stage2_vec[g] = stage2_reg;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Level fed to change detection

    generate
        for (g = 0; g < N_PINS; g = g + 1) begin : g_level
            reg level_reg;
            reg level_next;

            always @* begin
                // Raw path needs no synchroniser: pins already on this clock
                // Switching mode can itself show as one level step
                level_next = pick_level(filter_en_i, stage2_vec[g], pin_i[g]);
            end

            always @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    level_reg <= `PINS_RESET;
                end else begin
                    level_reg <= level_next;
                end
            end

            assign level_next_vec[g] = level_next;
            assign level_vec[g]      = level_reg;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Change events, one clock per level edge

    generate
        for (g = 0; g < N_PINS; g = g + 1) begin : g_change
            reg change_reg;
            reg change_next;

            always @* begin
                // Masking here keeps level tracking alive on output pins
                change_next = edge_event(level_next_vec[g], level_vec[g], dir_out_i[g]);
            end

            always @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    change_reg <= 1'h0;
                end else begin
                    change_reg <= change_next;
                end
            end

            assign change_vec[g] = change_reg;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Reset

    // Reset minimum of 120 us is kept by whoever drives rst_n_i
endmodule

// file: rtl/gpio_input_debounce_consts.vh
// Constants for the general-purpose input debounce filter
`ifndef GPIO_INPUT_DEBOUNCE_CONSTS_VH
`define GPIO_INPUT_DEBOUNCE_CONSTS_VH
`define CLK_SYS_PERIOD_NS   8
`define FILTER_PERIOD_US    50
`define FILTER_PERIOD_CYC   ((`FILTER_PERIOD_US * 1000) / `CLK_SYS_PERIOD_NS)
`define RESET_MIN_US        120
`define RESET_MIN_CYC       (((`RESET_MIN_US * 1000) + `CLK_SYS_PERIOD_NS - 1) / `CLK_SYS_PERIOD_NS)
`define PINS_RESET          1'h0
`endif

// file: rtl/filter_tick_gen.v
// Free-running divider making the slow filter clock tick
`timescale 1ns/1ns
module filter_tick_gen #(
    parameter PERIOD_CYC = 6250,
    parameter CW         = 16
) (
    input  wire clk_sys_i,
    input  wire rst_n_i,
    output reg  tick_o
);
    reg [CW-1:0] count_reg;
    reg [CW-1:0] count_next;

    always @* begin
        if ({{(32-CW){1'h0}}, count_reg} == PERIOD_CYC - 1) begin
            count_next = {CW{1'b0}};
        end else begin
            count_next = count_reg + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg <= {CW{1'b0}};
            tick_o    <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_o    <= (count_next == {CW{1'b0}});
        end
    end
endmodule

// file: sim/gpio_input_debounce_props.sv
// Checker for the input debounce filter
`timescale 1ns/1ns
module gpio_input_debounce_props #(
    parameter N_PINS     = 18,
    parameter PERIOD_CYC = 6250
) (
    input wire              clk_sys_i,
    input wire              rst_n_i,
    input wire              filter_en_i,
    input wire              tick_o,
    input wire [N_PINS-1:0] pin_i,
    input wire [N_PINS-1:0] dir_out_i,
    input wire [N_PINS-1:0] level_o,
    input wire [N_PINS-1:0] change_o
);
    reg [31:0] gap_reg;

    // Clocks since the last tick, so any period can be checked
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_reg <= 32'h0;
        end else if (tick_o) begin
            gap_reg <= 32'h1;
        end else begin
            gap_reg <= gap_reg + 32'h1;
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    chk_out_quiet: assert property (!(change_o & $past(dir_out_i))) else $error("output event");
    chk_edge_evt: assert property ($past(rst_n_i) |->
        change_o == ((level_o ^ $past(level_o)) & ~$past(dir_out_i))) else $error("bad event");
    chk_raw_path: assert property ($past(rst_n_i) && !$past(filter_en_i) |->
        level_o == $past(pin_i)) else $error("bypass level");
    chk_tick_gap: assert property (tick_o |-> gap_reg == PERIOD_CYC) else $error("tick gap");
    chk_filter_tick: assert property ($past(rst_n_i, 2) && $past(filter_en_i) && $past(filter_en_i, 2)
        && (level_o != $past(level_o)) |-> $past(tick_o, 2)) else $error("filtered level off tick");
    chk_two_sample: assert property ($past(rst_n_i, 2) && $past(filter_en_i) && $past(filter_en_i, 2) |->
        ((level_o ^ $past(level_o)) & (level_o ^ $past(pin_i, 2))) == '0) else $error("unconfirmed level");
    cov_filter_evt: cover property (filter_en_i && |change_o);
    cov_raw_evt: cover property (!filter_en_i && |change_o);
    cov_out_level: cover property (|(level_o & dir_out_i));
endmodule
bind gpio_input_debounce gpio_input_debounce_props #(
    .N_PINS     (N_PINS),
    .PERIOD_CYC (PERIOD_CYC)
) u_props (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .filter_en_i (filter_en_i),
    .tick_o      (tick_o),
    .pin_i       (pin_i),
    .dir_out_i   (dir_out_i),
    .level_o     (level_o),
    .change_o    (change_o)
);

// file: sim/gpio_pin_src.sv
// Signal sources on the input pins
`timescale 1ns/1ns
module gpio_pin_src (
    input  wire        clk_i,
    input  wire        glitch_i,
    input  wire [17:0] lvl_i,
    output reg  [17:0] pin_o
);
    // Inverted level lasts as many clocks as glitch_i is held
    always @(posedge clk_i) begin
        pin_o <= glitch_i ? ~lvl_i : lvl_i;
    end
endmodule

// file: sim/gpio_input_debounce_tb.sv
// Bench for the input debounce filter
`timescale 1ns/1ns
module gpio_input_debounce_tb;
    localparam [17:0] P = 18'h4;
    reg         clk_sys_i   = 1'h0;
    reg         rst_n_i     = 1'h0;
    reg         filter_en_i = 1'h0;
    reg         gl          = 1'h0;
    reg  [17:0] lvl         = 18'h0;
    reg  [17:0] dir_out_i   = 18'h0;
    reg  [17:0] exp_lvl;
    reg  [17:0] exp_ev;
    reg  [17:0] ev;
    // Row: filter, direction, pin level, expected level, expected events
    reg  [72:0] rows [0:3];
    wire [17:0] pin_i;
    wire [17:0] level_o;
    wire [17:0] change_o;
    wire        tick_o;
    integer     error_cnt = 0;
    integer     total_checks = 0;
    integer     i;
    integer     t;

    always #4 clk_sys_i = ~clk_sys_i;

    gpio_pin_src SRC (
        .clk_i    (clk_sys_i),
        .glitch_i (gl),
        .lvl_i    (lvl),
        .pin_o    (pin_i)
    );

    gpio_input_debounce #(
        .PERIOD_CYC (P)
    ) DUT (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .pin_i       (pin_i),
        .dir_out_i   (dir_out_i),
        .filter_en_i (filter_en_i),
        .level_o     (level_o),
        .change_o    (change_o),
        .tick_o      (tick_o)
    );

    task chk(input [63:0] nm, input [17:0] seen, input [17:0] exp); begin
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
        end
    end endtask

    // Gathers every event pulse over a window longer than two ticks
    task run(output [17:0] acc); begin
        acc = 18'h0;
        repeat (3 * P + 4) begin
            @(posedge clk_sys_i);
            #1 acc = acc | change_o;
        end
    end endtask

    task tally_and_finish; begin
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end endtask

    initial begin
        rows[0] = {1'h0, 18'h00000, 18'h3FFFF, 18'h3FFFF, 18'h3FFFF};
        rows[1] = {1'h1, 18'h00000, 18'h15555, 18'h15555, 18'h2AAAA};
        rows[2] = {1'h1, 18'h3FFFF, 18'h3FFFF, 18'h3FFFF, 18'h00000};
        rows[3] = {1'h0, 18'h2AAAA, 18'h00000, 18'h00000, 18'h15555};
        repeat (6) @(negedge clk_sys_i);
        chk("rst", level_o, 18'h0);
        rst_n_i = 1'h1;
        for (i = 0; i < 4; i = i + 1) begin
            @(negedge clk_sys_i);
            {filter_en_i, dir_out_i, lvl, exp_lvl, exp_ev} = rows[i];
            run(ev);
            chk("level", level_o, exp_lvl);
            chk("event", ev, exp_ev);
        end
        @(negedge clk_sys_i);
        filter_en_i = 1'h1;
        dir_out_i   = 18'h0;
        run(ev);
        chk("settle", ev, 18'h0);
        // Pulse spans exactly one tick, so the second sample must refuse it
        @(negedge clk_sys_i);
        gl = 1'h1;
        repeat (P) @(negedge clk_sys_i);
        gl = 1'h0;
        run(ev);
        chk("glitch", ev | level_o, 18'h0);
        @(negedge clk_sys_i);
        filter_en_i = 1'h0;
        gl = 1'h1;
        @(negedge clk_sys_i);
        gl = 1'h0;
        run(ev);
        chk("raw_glch", ev, 18'h3FFFF);
        chk("raw_lvl", level_o, 18'h0);
        @(negedge clk_sys_i);
        filter_en_i = 1'h1;
        lvl = 18'h00001;
        t = 0;
        while (level_o[0] !== 1'h1 && t < 4 * P) begin
            @(posedge clk_sys_i);
            #1 t = t + 1;
        end
        chk("delay", {17'h0, (t >= P + 2) && (t <= 2 * P + 2)}, 18'h1);
        @(negedge clk_sys_i);
        rst_n_i = 1'h0;
        #1;
        chk("rst", level_o, 18'h0);
        chk("rst_evt", change_o, 18'h0);
        repeat (6) @(negedge clk_sys_i);
        rst_n_i = 1'h1;
        t = 0;
        while (tick_o !== 1'h1 && t < 4 * P) begin
            @(posedge clk_sys_i);
            #1 t = t + 1;
            if (t == 2) begin
                chk("rel_lvl", level_o, 18'h0);
            end
        end
        chk("first_tk", t[17:0], P);
        tally_and_finish;
    end
endmodule
